// ===== design/boot_loader_and_status_io.sv
// Start-up loader control, option sampling, slave address match and status pins.
// Assumes an ADC sample of the option pins, 2 mV per lsb, and a link clock of 30 ns.
`timescale 1ns/100ps
`default_nettype none
module boot_loader_and_status_io
   import boot_io_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                lclk,
   input  wire logic                ext_reset,
   input  wire logic                disable_n_in,
   input  wire logic                scl_in,
   input  wire logic                sda_in,
   output logic                     scl_oe,
   output logic                     sda_oe,
   input  wire logic [9:0]          adc_sample,
   input  wire logic                adc_valid,
   output logic                     adc_sel_offset,
   input  wire logic [num_gpio-1:0] gpio_in,
   output logic [num_gpio-1:0]      gpio_out,
   output logic [num_gpio-1:0]      gpio_oe,
   input  wire logic [2:0]          op_state,
   input  wire logic                charger_port,
   input  wire logic                demod_cfg,
   output logic                     loading,
   output logic                     rom_fallback,
   output logic [3:0]               led_option,
   output logic                     led_option_bad,
   output logic [9:0]               offset_sample,
   output logic                     over_temp,
   output logic                     slave_hit,
   output logic [7:0]               fw_byte,
   output logic                     fw_byte_stb
);
   // Run request: reset high or disable high hold all outputs but over_temp, fw_byte and fw_byte_stb in defaults
   logic [2:0] rst_sync;
   logic [2:0] en_sync;
   logic       hold;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rst_sync <= 3'b111; en_sync <= 3'b111;
      end else begin
         rst_sync <= {rst_sync[1:0], ext_reset};
         en_sync  <= {en_sync[1:0], disable_n_in};
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) hold <= 1'b1;
      else if (rst_sync[2] == rst_sync[1] && en_sync[2] == en_sync[1])
         hold <= rst_sync[2] | en_sync[2];
   end

   // Link domain reset follows hold through a two-stage synchroniser
   logic [1:0] lrst_sync;
   always_ff @(posedge lclk or posedge rst) begin
      if (rst) lrst_sync <= 2'b11;
      else lrst_sync <= {lrst_sync[0], hold};
   end

   // Power-on sequence: sample LED option, then offset, then fetch
   typedef enum logic [1:0] {
      p_led   = 2'b00,
      p_ofs   = 2'b01,
      p_load  = 2'b10,
      p_run   = 2'b11
   } boot_state_type;
   boot_state_type bstate;
   logic       fetch_done;
   logic       fetch_rom;
   logic [7:0] fetch_byte;
   logic       fetch_tgl;
   logic       scl_oe_l;
   logic       sda_oe_l;
   logic [2:0] done_sync;
   logic [2:0] tgl_sync;
   logic       sda_meta_l;
   logic       sda_l;
   logic       start_l;
   logic [1:0] start_sync;

   function automatic logic [3:0] decode_option(input logic [9:0] v);
      int mv;
      logic [3:0] res;
      mv = 2 * int'(v);
      res = 4'h0;
      if (v <= mv_opt1_max) res = 4'h1;
      else if (v >= mv_opt10_min) res = 4'ha;
      else
         for (int k = 2; k <= 9; k++)
            if (mv * 100 >= opt_nom_mv[k] * (100 - tol_pct) &&
                mv * 100 <= opt_nom_mv[k] * (100 + tol_pct)) res = 4'(k);
      return res;
   endfunction : decode_option

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bstate <= p_led; led_option <= 4'h0; led_option_bad <= 1'b0;
         offset_sample <= 10'h000; adc_sel_offset <= 1'b0;
      end else if (hold) begin
         bstate <= p_led; adc_sel_offset <= 1'b0;
         led_option <= 4'h0; led_option_bad <= 1'b0; offset_sample <= 10'h000;
      end else begin
         unique case (bstate)
            p_led: if (adc_valid) begin
               led_option <= decode_option(adc_sample);
               led_option_bad <= decode_option(adc_sample) inside {4'h0, 4'h7, 4'h8, 4'h9};
               adc_sel_offset <= 1'b1; bstate <= p_ofs;
            end
            p_ofs: if (adc_valid) begin
               offset_sample <= adc_sample;
               bstate <= p_load;
            end
            p_load: if (done_sync[2] && done_sync[1]) bstate <= p_run;
            p_run: bstate <= p_run;
         endcase
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) loading <= 1'b0;
      else loading <= (bstate == p_load) && !hold;
   end

   // Start request crosses into the link domain as a level
   always_ff @(posedge lclk or posedge rst) begin
      if (rst) start_sync <= 2'b00;
      else start_sync <= {start_sync[0], loading};
   end
   assign start_l = start_sync[1];
   always_ff @(posedge lclk or posedge rst) begin
      if (rst) begin
         sda_meta_l <= 1'b1; sda_l <= 1'b1;
      end else begin
         sda_meta_l <= sda_in; sda_l <= sda_meta_l;
      end
   end

   // The fetch master assumes sole ownership of the bus while loading
   eeprom_fetch u_fetch (
      .lclk      (lclk),
      .lrst      (lrst_sync[1]),
      .start     (start_l),
      .sda_in    (sda_l),
      .scl_oe    (scl_oe_l),
      .sda_oe    (sda_oe_l),
      .done      (fetch_done),
      .from_rom  (fetch_rom),
      .byte_data (fetch_byte),
      .byte_tgl  (fetch_tgl)
   );

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         done_sync <= 3'b000; tgl_sync <= 3'b000;
      end else begin
         done_sync <= {done_sync[1:0], fetch_done};
         tgl_sync  <= {tgl_sync[1:0], fetch_tgl};
      end
   end
   // Byte changes in the same link cycle as its toggle and then holds for many link cycles, so a grab after the synchronised toggle is safe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fw_byte <= 8'h00; fw_byte_stb <= 1'b0;
      end else begin
         fw_byte_stb <= tgl_sync[2] ^ tgl_sync[1];
         if (tgl_sync[2] ^ tgl_sync[1]) fw_byte <= fetch_byte;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rom_fallback <= 1'b0;
      else if (hold) rom_fallback <= 1'b0;
      else if (bstate == p_run && !rom_fallback) rom_fallback <= fetch_rom;
   end

   // Bus drive: master enables while loading, then slave ack only
   logic [2:0] scl_s;
   logic [2:0] sda_s;
   logic [3:0] sbit;
   logic [7:0] sshift;
   logic       sbusy;
   logic       sack;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         scl_s <= 3'b111; sda_s <= 3'b111;
      end else begin
         scl_s <= {scl_s[1:0], scl_in};
         sda_s <= {sda_s[1:0], sda_in};
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sbit <= 4'h0; sshift <= 8'h00; sbusy <= 1'b0; sack <= 1'b0; slave_hit <= 1'b0;
      end else if (bstate != p_run) begin
         sbusy <= 1'b0; sack <= 1'b0; slave_hit <= 1'b0;
      end else begin
         slave_hit <= 1'b0;
         if (scl_s[2] && scl_s[1] && sda_s[2] && !sda_s[1]) begin
            sbusy <= 1'b1; sbit <= 4'h0;
         end else if (scl_s[2] && scl_s[1] && !sda_s[2] && sda_s[1]) begin
            sbusy <= 1'b0; sack <= 1'b0;
         end else if (sbusy && !scl_s[2] && scl_s[1]) begin
            if (sbit < 4'h8) sshift <= {sshift[6:0], sda_s[1]};
            sbit <= sbit + 4'h1;
         end else if (sbusy && scl_s[2] && !scl_s[1]) begin
            if (sbit == 4'h8 && sshift[7:1] == slave_addr) begin
               sack <= 1'b1; slave_hit <= 1'b1;
            end
            if (sbit == 4'h9) begin
               sack <= 1'b0; sbusy <= 1'b0;
            end
         end
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         scl_oe <= 1'b0; sda_oe <= 1'b0;
      end else if (bstate == p_run) begin
         scl_oe <= 1'b0; sda_oe <= sack;
      end else begin
         scl_oe <= scl_oe_l & loading; sda_oe <= sda_oe_l & loading;
      end
   end

   // Blink divider and LED action table
   logic [26:0] bcnt;
   logic [6:0]  pct;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) bcnt <= 27'h0;
      else if (bcnt == 27'(blink_period_1hz - 1)) bcnt <= 27'h0;
      else bcnt <= bcnt + 27'h1;
   end
   assign pct = 7'((bcnt / 27'(clk_hz / 100)));
   function automatic logic blink_level(input led_act_type a, input logic [26:0] c, input logic [6:0] p);
      logic r;
      r = 1'b0;
      unique case (a)
         led_off: r = 1'b0;
         led_on:  r = 1'b1;
         led_b1:  r = (c < 27'(blink_1hz_half));
         led_b2:  r = (c % 27'(blink_1hz_half)) < 27'(blink_1hz_half / 2);
         led_b4:  r = (c % 27'(blink_1hz_half / 2)) < 27'(blink_1hz_half / 4);
         led_blp: r = (p < 7'(low_power_on_pct));
         default: r = 1'b0;
      endcase
      return r;
   endfunction : blink_level
   led_act_type green_act;
   led_act_type red_act;
   always_comb begin
      green_act = led_off;
      red_act = led_off;
      unique case (led_option)
         4'h1: begin green_act = (op_state == st_transfer) ? led_b1 : (op_state == st_complete) ? led_on :
                  (op_state == st_lowpower) ? led_blp : led_off;
            red_act = (op_state == st_standby) ? led_on : (op_state == st_fault) ? led_b4 : led_off; end
         4'h3: green_act = (op_state == st_transfer) ? led_b1 : (op_state == st_complete) ? led_on :
                  (op_state == st_fault) ? led_b4 : (op_state == st_lowpower) ? led_blp : led_off;
         4'h6: begin green_act = (op_state == st_complete) ? led_on : led_off;
            red_act = (op_state == st_transfer) ? led_on : (op_state == st_fault) ? led_b4 :
                  (op_state == st_lowpower) ? led_blp : led_off; end
         4'ha: begin green_act = (op_state == st_transfer) ? led_b1 : (op_state == st_complete) ? led_on :
                  (op_state == st_lowpower) ? led_blp : led_off;
            red_act = (op_state == st_fault) ? led_b4 : led_off; end
         default: begin green_act = (op_state == st_transfer || op_state == st_complete) ? led_on :
                  (op_state == st_lowpower) ? led_blp : led_off;
            red_act = (op_state == st_fault) ? led_b4 : led_off; end
      endcase
   end

   // Buzzer square wave while power transfer is shown
   logic [15:0] bzcnt;
   logic        bz;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bzcnt <= 16'h0000; bz <= 1'b0;
      end else if (bzcnt == 16'(buzz_half - 1)) begin
         bzcnt <= 16'h0000; bz <= ~bz;
      end else bzcnt <= bzcnt + 16'h0001;
   end

   // Thermistor input is sampled through three stages
   logic [2:0] therm_s;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         therm_s <= 3'b000; over_temp <= 1'b0;
      end else begin
         therm_s <= {therm_s[1:0], gpio_in[2]};
         if (therm_s[2] == therm_s[1]) over_temp <= therm_s[2];
      end
   end

   // Pin assignment: all inputs until firmware runs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gpio_oe <= 7'h00; gpio_out <= 7'h00;
      end else if (bstate != p_run) begin
         gpio_oe <= 7'h00; gpio_out <= 7'h00;
      end else begin
         gpio_oe <= 7'h7b;
         gpio_out[0] <= 1'b1; // inactive high of an active-low output
         gpio_out[1] <= demod_cfg;
         gpio_out[2] <= 1'b0;
         gpio_out[3] <= blink_level(green_act, bcnt, pct);
         gpio_out[4] <= bz & (op_state == st_transfer);
         gpio_out[5] <= charger_port;
         gpio_out[6] <= blink_level(red_act, bcnt, pct);
      end
   end
endmodule : boot_loader_and_status_io
`default_nettype wire

// ===== design/boot_io_pkg.sv
// Constants shared by the start-up loader and status pin logic.
// Assumes a 100 MHz system clock and a separate I2C link clock domain.
package boot_io_pkg;
   localparam int  clk_hz          = 100_000_000;
   localparam int  link_fast_hz    = 300_000;
   localparam int  link_slow_hz    = 100_000;
   localparam int  link_clk_hz     = 33_333_333;
   // Quarter-bit divider counts on the link clock
   localparam int  fast_div        = link_clk_hz / (4 * link_fast_hz);
   localparam int  slow_div        = link_clk_hz / (4 * link_slow_hz);
   localparam logic [6:0] eeprom_addr   = 7'h52;
   localparam logic [6:0] slave_addr    = 7'h39;
   localparam logic [1:0] first_ee_addr = 2'h0;
   localparam logic [1:0] last_ee_addr  = 2'h3;
   localparam int  num_gpio        = 7;
   // Millivolt thresholds on a 10-bit sample, 1 lsb = 2 mV
   localparam logic [9:0] mv_opt1_max  = 10'h028; // 80 mV
   localparam logic [9:0] mv_opt10_min = 10'h2ee; // 1500 mV
   localparam int  opt_nom_mv [2:9] = '{220, 370, 510, 660, 810, 1000, 1100, 1250};
   localparam int  tol_pct         = 3;
   localparam int  blink_1hz_half  = clk_hz / 2;
   localparam int  blink_period_1hz = clk_hz;
   localparam int  low_power_on_pct = 80;
   localparam int  buzz_half       = clk_hz / 4000;
   typedef enum logic [2:0] {
      st_standby  = 3'b000,
      st_transfer = 3'b001,
      st_complete = 3'b010,
      st_fault    = 3'b011,
      st_lowpower = 3'b100
   } op_state_type;
   typedef enum logic [2:0] {
      led_off  = 3'b000,
      led_on   = 3'b001,
      led_b1   = 3'b010,
      led_b2   = 3'b011,
      led_b4   = 3'b100,
      led_blp  = 3'b101
   } led_act_type;
endpackage : boot_io_pkg

// ===== design/eeprom_fetch.sv
// I2C master that probes and reads the firmware image, clocked by the link clock.
// Assumes the bus wires are resolved outside from the enables, pulled up.
`timescale 1ns/100ps
`default_nettype none
module eeprom_fetch
   import boot_io_pkg::*;
(
   input  wire logic       lclk,
   input  wire logic       lrst,
   input  wire logic       start,
   input  wire logic       sda_in,
   output logic            scl_oe,
   output logic            sda_oe,
   output logic            done,
   output logic            from_rom,
   output logic [7:0]      byte_data,
   output logic            byte_tgl
);
   typedef enum logic [2:0] {
      f_idle  = 3'b000,
      f_start = 3'b001,
      f_bit   = 3'b010,
      f_ack   = 3'b011,
      f_stop  = 3'b100,
      f_end   = 3'b101
   } fetch_state_type;
   fetch_state_type state;
   logic [11:0] qcnt;
   logic [1:0]  phase;
   logic [3:0]  bitn;
   logic [7:0]  shreg;
   logic        fast;
   logic [1:0]  ee_addr;
   logic        reading;
   logic [15:0] bytes_left;
   logic        tick;
   // Open-drain: driving low is the only active level
   assign tick = (qcnt == (fast ? 12'(fast_div) : 12'(slow_div)));
   always_ff @(posedge lclk or posedge lrst) begin
      if (lrst) qcnt <= 12'h000;
      else if (tick || state == f_idle) qcnt <= 12'h000;
      else qcnt <= qcnt + 12'h001;
   end
   always_ff @(posedge lclk or posedge lrst) begin
      if (lrst) begin
         state <= f_idle; phase <= 2'h0; bitn <= 4'h0; shreg <= 8'h00;
         fast <= 1'b1; ee_addr <= 2'h0; reading <= 1'b0;
         bytes_left <= 16'h0000; scl_oe <= 1'b0; sda_oe <= 1'b0;
         done <= 1'b0; from_rom <= 1'b0; byte_data <= 8'h00; byte_tgl <= 1'b0;
      end else begin
         unique case (state)
            f_idle: if (start) begin
               fast <= 1'b1; ee_addr <= first_ee_addr;
               state <= f_start; phase <= 2'h0;
            end
            f_start: if (tick) begin
               phase <= phase + 2'h1;
               if (phase == 2'h0) sda_oe <= 1'b1;
               if (phase == 2'h1) begin
                  scl_oe <= 1'b1;
                  // First try lands on the base address itself, later tries step upwards
                  shreg <= {eeprom_addr + 7'(ee_addr), 1'b1};
                  bitn <= 4'h0; state <= f_bit; phase <= 2'h0;
               end
            end
            f_bit: if (tick) begin
               phase <= phase + 2'h1;
               if (phase == 2'h0) sda_oe <= reading ? 1'b0 : ~shreg[7];
               if (phase == 2'h1) scl_oe <= 1'b0;
               if (phase == 2'h2 && reading) shreg <= {shreg[6:0], sda_in};
               if (phase == 2'h3) begin
                  scl_oe <= 1'b1;
                  if (!reading) shreg <= {shreg[6:0], 1'b0};
                  bitn <= bitn + 4'h1;
                  if (bitn == 4'h7) state <= f_ack;
               end
            end
            f_ack: if (tick) begin
               phase <= phase + 2'h1;
               if (phase == 2'h0) sda_oe <= reading && bytes_left != 16'h0001;
               if (phase == 2'h1) scl_oe <= 1'b0;
               if (phase == 2'h2 && !reading) begin
                  if (sda_in) begin // No acknowledge
                     if (ee_addr == last_ee_addr) from_rom <= 1'b1;
                     else begin
                        fast <= 1'b0; ee_addr <= ee_addr + 2'h1;
                     end
                     state <= f_stop;
                  end else begin
                     reading <= 1'b1; bytes_left <= 16'hffff;
                  end
               end
               if (phase == 2'h2 && reading) begin
                  byte_data <= shreg; byte_tgl <= ~byte_tgl;
                  bytes_left <= bytes_left - 16'h0001;
               end
               if (phase == 2'h3) begin
                  scl_oe <= 1'b1; bitn <= 4'h0;
                  if (reading && bytes_left == 16'h0000) state <= f_stop;
                  else if (state == f_ack) state <= f_bit;
               end
            end
            f_stop: if (tick) begin
               phase <= phase + 2'h1;
               if (phase == 2'h0) sda_oe <= 1'b1;
               if (phase == 2'h1) scl_oe <= 1'b0;
               if (phase == 2'h2) sda_oe <= 1'b0;
               if (phase == 2'h3) begin
                  if (reading || from_rom) state <= f_end;
                  else state <= f_start;
               end
            end
            f_end: begin
               scl_oe <= 1'b0; sda_oe <= 1'b0;
               done <= 1'b1;
            end
            default: state <= f_idle;
         endcase
      end
   end
endmodule : eeprom_fetch
`default_nettype wire

// ===== verif/boot_loader_and_status_io_props.sv
// Checker for the loader and status pins, watching only the top module's ports.
// Assumes a bind to every instance of the loader block.
`timescale 1ns/100ps
`default_nettype none
module boot_loader_and_status_io_props
   import boot_io_pkg::*;
(
   input wire logic                mclk,
   input wire logic                rst,
   input wire logic                ext_reset,
   input wire logic                disable_n_in,
   input wire logic                scl_oe,
   input wire logic [9:0]          adc_sample,
   input wire logic                adc_valid,
   input wire logic                adc_sel_offset,
   input wire logic [num_gpio-1:0] gpio_in,
   input wire logic [num_gpio-1:0] gpio_out,
   input wire logic [num_gpio-1:0] gpio_oe,
   input wire logic                charger_port,
   input wire logic                loading,
   input wire logic                rom_fallback,
   input wire logic [3:0]          led_option,
   input wire logic                over_temp
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Six quiet cycles cover the three-flop pin synchroniser
   sequence settled;
      (!ext_reset && !disable_n_in)[*6];
   endsequence
   sequence end_sample;
      $rose(adc_valid) && !adc_sel_offset && !loading && !rom_fallback && led_option == 4'h0
         && (adc_sample <= mv_opt1_max || adc_sample >= mv_opt10_min);
   endsequence
   a_reset_hold: assert property (ext_reset[*8] |-> !loading && gpio_oe == '0 && led_option == 4'h0)
      else $error("ext reset did not hold defaults");
   a_disable_hold: assert property (disable_n_in[*8] |-> !loading && gpio_oe == '0 && led_option == 4'h0)
      else $error("disable did not hold defaults");
   a_inputs_startup: assert property (loading |-> gpio_oe == '0)
      else $error("pin driven during start-up");
   a_bus_released: assert property (gpio_oe[6] |-> !loading && !scl_oe)
      else $error("clock line driven in normal operation");
   a_port_type: assert property ((gpio_oe[5] && $stable(charger_port))[*6] |-> gpio_out[5] == charger_port)
      else $error("port type pin wrong");
   a_spare_idle: assert property (gpio_oe[0] |-> gpio_out[0])
      else $error("spare pin not idle high");
   a_over_temp: assert property ((gpio_oe[6] && $stable(gpio_in[2]))[*6] |-> over_temp == gpio_in[2])
      else $error("over temperature flag wrong");
   a_led_once: assert property (settled ##0 led_option != 4'h0 |=> $stable(led_option))
      else $error("led option changed after sampling");
   a_led_ends: assert property (settled ##0 end_sample |=>
      led_option == ($past(adc_sample) <= mv_opt1_max ? 4'h1 : 4'ha))
      else $error("end led option decoded wrong");
   a_master_start: assert property ($rose(loading) |-> ##[1:1000] scl_oe)
      else $error("loader did not start mastering");
endmodule : boot_loader_and_status_io_props
bind boot_loader_and_status_io boot_loader_and_status_io_props u_props (.*);
`default_nettype wire

// ===== verif/eeprom_listener.sv
// Stand-in for an absent firmware memory: it listens and never answers.
// Assumes resolved, pulled-up clock and data lines.
`timescale 1ns/100ps
`default_nettype none
module eeprom_listener (
   input  wire logic  scl,
   input  wire logic  sda,
   output int         n_addr,
   output logic [7:0] first_addr,
   output realtime    per_first,
   output realtime    per_last
);
   int         nbit = 9;
   logic [7:0] sh = '0;
   realtime    t_last = 0;
   initial n_addr = 0;
   initial first_addr = '0;
   initial per_first = 0;
   initial per_last = 0;
   // Passive only, never a second master on the bus
   always @(negedge sda) if (scl) nbit = 0;
   always @(posedge scl) begin
      if (nbit > 0 && nbit < 8) per_last = $realtime - t_last;
      if (nbit > 0 && nbit < 8 && n_addr == 0) per_first = per_last;
      t_last = $realtime;
      if (nbit < 8) sh = {sh[6:0], sda};
      if (nbit == 7 && n_addr == 0) first_addr = sh;
      if (nbit == 7) n_addr++;
      nbit++;
   end
endmodule : eeprom_listener
`default_nettype wire

// ===== verif/boot_loader_and_status_io_tb.sv
// Bench: option decode across holds, fetch fallback, status pins, slave match.
// Assumes package, design, listener and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module boot_loader_and_status_io_tb;
   import boot_io_pkg::*;
   logic       mclk = 0, rst = 1, lclk = 0, ext_reset = 0, disable_n_in = 0, adc_valid = 0;
   logic       charger_port = 0, demod_cfg = 0, hold_scl = 0, hold_sda = 0;
   logic [9:0] adc_sample = '0;
   logic [6:0] gpio_in = '0;
   logic [2:0] op_state = '0;
   logic       scl_oe, sda_oe, adc_sel_offset, loading, rom_fallback, led_option_bad, over_temp;
   logic       slave_hit, fw_byte_stb;
   logic [6:0] gpio_out, gpio_oe;
   logic [3:0] led_option;
   logic [9:0] offset_sample;
   logic [7:0] fw_byte, first_addr;
   int         n_addr, num_errors = 0, comparisons = 0, hits = 0;
   realtime    per_first, per_last;
   wire logic  scl_in = !(scl_oe || hold_scl);
   wire logic  sda_in = !(sda_oe || hold_sda);
   logic [9:0] smp [11] = '{10'h028, 10'h071, 10'h0b4, 10'h0ff, 10'h14a, 10'h195,
                            10'h1f4, 10'h226, 10'h271, 10'h04b, 10'h2ee};
   logic [3:0] opt [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0, 4'h0, 4'h0, 4'h0, 4'ha};
   always #5 mclk = ~mclk;
   initial begin
      #7;
      forever #15 lclk = ~lclk;
   end
   always @(posedge mclk) if (slave_hit) hits <= hits + 1;
   boot_loader_and_status_io u_boot_loader_and_status_io (.*);
   eeprom_listener u_eeprom_listener (.scl(scl_in), .sda(sda_in), .n_addr, .first_addr, .per_first, .per_last);
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic pulse(input logic [9:0] v);
      adc_sample = v;
      adc_valid = 1;
      cyc(1);
      adc_valid = 0;
      cyc(3);
   endtask : pulse
   // Slow bit timing, well inside what a slave must follow
   task automatic send_addr(input logic [7:0] b);
      hold_sda = 1;
      cyc(50);
      for (int i = 8; i >= 0; i--) begin
         hold_scl = 1;
         cyc(25);
         hold_sda = (i > 0) ? !b[i-1] : 1'b0;
         cyc(25);
         hold_scl = 0;
         cyc(50);
      end
      hold_scl = 1;
      hold_sda = 1;
      cyc(50);
      hold_scl = 0;
      cyc(25);
      hold_sda = 0;
      cyc(50);
   endtask : send_addr
   task automatic end_of_test;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   initial begin
      cyc(10);
      rst = 0;
      for (int i = 0; i < 11; i++) begin
         if (i % 2 == 1) ext_reset = 1;
         else disable_n_in = 1;
         cyc(10);
         chk("loading", 0, loading);
         chk("led_option", 0, led_option);
         chk("gpio_oe", 0, gpio_oe);
         ext_reset = 0;
         disable_n_in = 0;
         cyc(8);
         pulse(smp[i]);
         chk("led_option_bad", opt[i] == 0, led_option_bad);
         chk("adc_sel_offset", 1, adc_sel_offset);
         if (opt[i] != 0) chk("led_option", opt[i], led_option);
      end
      pulse(10'h123);
      chk("offset_sample", 10'h123, offset_sample);
      chk("loading", 1, loading);
      pulse(10'h028);
      chk("led_option", 4'ha, led_option);
      for (int w = 0; w < 60000 && !rom_fallback; w++) cyc(1);
      chk("rom_fallback", 1, rom_fallback);
      chk("loading", 0, loading);
      chk("scl_oe", 0, scl_oe);
      chk("sda_oe", 0, sda_oe);
      chk("fw_byte_stb", 0, fw_byte_stb);
      chk("addr_tries", 4, n_addr);
      chk("first_addr", eeprom_addr, first_addr[7:1]);
      chk("fast_period", 1, per_first > 3000 && per_first < 3700);
      chk("slow_period", 1, per_last > 9000 && per_last < 11000);
      for (int k = 1; k >= 0; k--) begin
         charger_port = k[0];
         demod_cfg = k[0];
         gpio_in = k[0] ? 7'h04 : 7'h00;
         cyc(8);
         chk("gpio_out", k[0] ? 7'h23 : 7'h01, gpio_out);
         chk("over_temp", k[0], over_temp);
         chk("gpio_oe", 7'h7b, gpio_oe);
      end
      send_addr(8'h72);
      send_addr(8'h74);
      send_addr(8'ha4);
      chk("slave_hits", 1, hits);
      end_of_test();
   end
   initial begin
      repeat (80000) @(posedge mclk);
      num_errors++;
      end_of_test();
   end
endmodule : boot_loader_and_status_io_tb
`default_nettype wire
